// ### design/sgl_limiter.sv
// Speaker gain limiter control: registers, detectors, attack/decay
// sequencing and zero-cross gated attenuation in 0.5 dB steps.
// Assumes decoded register writes/reads and synchronous comparator inputs.
`timescale 1ns/1ps
module sgl_limiter #(
   parameter int unsigned TICK_CYCLES = sgl_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic reg_we,
   input wire logic reg_re,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata_q,
   input wire logic clip_trip,
   input wire logic power_trip_rms,
   input wire logic power_trip_inst,
   input wire logic zero_cross,
   input wire logic [5:0] speaker_volume_stage,
   output logic [3:0] clip_headroom_threshold_q,
   output logic [3:0] power_limit_threshold_q,
   output logic power_measure_mode_q,
   output logic [6:0] atten_q,
   output logic [6:0] speaker_gain_q,
   output logic limiting_q
);

   localparam int unsigned CW = sgl_pkg::STEP_CNT_W;

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   logic master_en_q, master_en_d;
   logic clip_en_q, clip_en_d;
   logic [3:0] clip_thr_d;
   logic [2:0] clip_atk_q, clip_atk_d;
   logic [2:0] clip_dcy_q, clip_dcy_d;
   logic pwr_en_q, pwr_en_d;
   logic pwr_mode_d;
   logic [3:0] pwr_thr_d;
   logic [2:0] pwr_atk_q, pwr_atk_d;
   logic [2:0] pwr_dcy_q, pwr_dcy_d;
   logic ramp_q, ramp_d;
   logic [5:0] floor_q, floor_d;
   logic [15:0] rdata_d;

   // Register writes; reserved bits are dropped and read back as zero
   always_comb begin
      master_en_d = master_en_q;
      clip_en_d = clip_en_q;
      clip_thr_d = clip_headroom_threshold_q;
      clip_atk_d = clip_atk_q;
      clip_dcy_d = clip_dcy_q;
      pwr_en_d = pwr_en_q;
      pwr_mode_d = power_measure_mode_q;
      pwr_thr_d = power_limit_threshold_q;
      pwr_atk_d = pwr_atk_q;
      pwr_dcy_d = pwr_dcy_q;
      ramp_d = ramp_q;
      floor_d = floor_q;
      if (reg_we) begin
         case (reg_addr)
            sgl_pkg::PWR_MGMT3_ADDR: begin
               master_en_d = reg_wdata[sgl_pkg::MASTER_EN_BIT];
            end
            sgl_pkg::CLIP_CTRL_ADDR: begin
               clip_en_d = reg_wdata[sgl_pkg::DET_EN_BIT];
               clip_thr_d = reg_wdata[sgl_pkg::THR_LSB +: 4];
               clip_atk_d = reg_wdata[sgl_pkg::ATK_LSB +: 3];
               clip_dcy_d = reg_wdata[sgl_pkg::DCY_LSB +: 3];
            end
            sgl_pkg::PWR_CTRL_ADDR: begin
               pwr_en_d = reg_wdata[sgl_pkg::DET_EN_BIT];
               pwr_mode_d = reg_wdata[sgl_pkg::MEAS_MODE_BIT];
               pwr_thr_d = reg_wdata[sgl_pkg::THR_LSB +: 4];
               pwr_atk_d = reg_wdata[sgl_pkg::ATK_LSB +: 3];
               pwr_dcy_d = reg_wdata[sgl_pkg::DCY_LSB +: 3];
            end
            sgl_pkg::LIM_CTRL2_ADDR: begin
               ramp_d = reg_wdata[sgl_pkg::RAMP_BIT];
               floor_d = reg_wdata[sgl_pkg::FLOOR_LSB +: 6];
            end
            default: begin
            end
         endcase
      end
   end

   // Read data is registered; unmapped addresses read as zero
   always_comb begin
      rdata_d = reg_rdata_q;
      if (reg_re) begin
         rdata_d = 16'h0000;
         case (reg_addr)
            sgl_pkg::PWR_MGMT3_ADDR: begin
               rdata_d[sgl_pkg::MASTER_EN_BIT] = master_en_q;
            end
            sgl_pkg::CLIP_CTRL_ADDR: begin
               rdata_d[sgl_pkg::DET_EN_BIT] = clip_en_q;
               rdata_d[sgl_pkg::THR_LSB +: 4] = clip_headroom_threshold_q;
               rdata_d[sgl_pkg::ATK_LSB +: 3] = clip_atk_q;
               rdata_d[sgl_pkg::DCY_LSB +: 3] = clip_dcy_q;
            end
            sgl_pkg::PWR_CTRL_ADDR: begin
               rdata_d[sgl_pkg::DET_EN_BIT] = pwr_en_q;
               rdata_d[sgl_pkg::MEAS_MODE_BIT] = power_measure_mode_q;
               rdata_d[sgl_pkg::THR_LSB +: 4] = power_limit_threshold_q;
               rdata_d[sgl_pkg::ATK_LSB +: 3] = pwr_atk_q;
               rdata_d[sgl_pkg::DCY_LSB +: 3] = pwr_dcy_q;
            end
            sgl_pkg::LIM_CTRL2_ADDR: begin
               rdata_d[sgl_pkg::RAMP_BIT] = ramp_q;
               rdata_d[sgl_pkg::FLOOR_LSB +: 6] = floor_q;
            end
            sgl_pkg::LIM_STATUS_ADDR: begin
               rdata_d[sgl_pkg::LIMITING_BIT] = limiting_q;
               rdata_d[6:0] = atten_q;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         master_en_q <= sgl_pkg::MASTER_EN_RST;
         clip_en_q <= sgl_pkg::CLIP_EN_RST;
         clip_headroom_threshold_q <= sgl_pkg::CLIP_THR_RST;
         clip_atk_q <= sgl_pkg::CLIP_ATK_RST;
         clip_dcy_q <= sgl_pkg::CLIP_DCY_RST;
         pwr_en_q <= sgl_pkg::PWR_EN_RST;
         power_measure_mode_q <= sgl_pkg::PWR_MODE_RST;
         power_limit_threshold_q <= sgl_pkg::PWR_THR_RST;
         pwr_atk_q <= sgl_pkg::PWR_ATK_RST;
         pwr_dcy_q <= sgl_pkg::PWR_DCY_RST;
         ramp_q <= sgl_pkg::RAMP_RST;
         floor_q <= sgl_pkg::FLOOR_RST;
         reg_rdata_q <= 16'h0000;
      end else begin
         master_en_q <= master_en_d;
         clip_en_q <= clip_en_d;
         clip_headroom_threshold_q <= clip_thr_d;
         clip_atk_q <= clip_atk_d;
         clip_dcy_q <= clip_dcy_d;
         pwr_en_q <= pwr_en_d;
         power_measure_mode_q <= pwr_mode_d;
         power_limit_threshold_q <= pwr_thr_d;
         pwr_atk_q <= pwr_atk_d;
         pwr_dcy_q <= pwr_dcy_d;
         ramp_q <= ramp_d;
         floor_q <= floor_d;
         reg_rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Detectors and rate selection
   // ----------------------------------------------------------------
   logic clip_act, pwr_trip, pwr_act, any_act;
   logic [CW-1:0] atk_limit, dcy_limit;
   logic [9:0] tick_cnt_q, tick_cnt_d;
   logic tick_q, tick_d;
   logic atk_step, dcy_step;
   sgl_pkg::sgl_state_t state_q, state_d;
   logic clip_seen_q, clip_seen_d;
   logic pwr_seen_q, pwr_seen_d;

   // The analogue side turns output voltage into a power comparison
   // for the selected threshold; mode picks which trip is used
   assign pwr_trip = power_measure_mode_q ? power_trip_rms
                                          : power_trip_inst;
   assign clip_act = master_en_q && clip_en_q && clip_trip;
   assign pwr_act = master_en_q && pwr_en_q && pwr_trip;
   assign any_act = clip_act || pwr_act;

   // Step interval in ticks is the per-6dB time over twelve steps
   always_comb begin
      if (clip_act) begin
         atk_limit = CW'(sgl_pkg::CLIP_ATK_US[clip_atk_q]
                         / sgl_pkg::STEPS_PER_6DB);
      end else begin
         atk_limit = CW'(sgl_pkg::PWR_ATK_US[pwr_atk_q]
                         / sgl_pkg::STEPS_PER_6DB);
      end
      // Decay follows the power setting whenever power tripped at all
      if (clip_seen_q && !pwr_seen_q) begin
         dcy_limit = CW'(sgl_pkg::CLIP_DCY_US[clip_dcy_q]
                         / sgl_pkg::STEPS_PER_6DB);
      end else begin
         dcy_limit = CW'(sgl_pkg::PWR_DCY_US[pwr_dcy_q]
                         / sgl_pkg::STEPS_PER_6DB);
      end
   end

   // Microsecond prescaler shared by both step timers
   always_comb begin
      tick_d = 1'b0;
      tick_cnt_d = tick_cnt_q + 10'h001;
      if (tick_cnt_q >= 10'(TICK_CYCLES - 1)) begin
         tick_cnt_d = 10'h000;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tick_cnt_q <= 10'h000;
         tick_q <= 1'b0;
      end else begin
         tick_cnt_q <= tick_cnt_d;
         tick_q <= tick_d;
      end
   end

   sgl_step_timer #(.CNT_W(CW)) u_atk_timer (
      .clk(clk),
      .rst_b(rst_b),
      .run((state_q == sgl_pkg::ST_ATTACK) && any_act),
      .tick(tick_q),
      .limit(atk_limit),
      .step_q(atk_step)
   );

   sgl_step_timer #(.CNT_W(CW)) u_dcy_timer (
      .clk(clk),
      .rst_b(rst_b),
      .run(state_q == sgl_pkg::ST_DECAY),
      .tick(tick_q),
      .limit(dcy_limit),
      .step_q(dcy_step)
   );

   // ----------------------------------------------------------------
   // Attenuation sequencing
   // ----------------------------------------------------------------
   logic [4:0] pend_q, pend_d, pend_sum, apply_n;
   logic [6:0] atten_d, limit_hd, gain_d;
   logic [7:0] up_sum;
   logic limiting_d;

   // Largest cut keeps the path at or above the floor gain
   assign limit_hd = (speaker_volume_stage > floor_q) ?
                     {speaker_volume_stage - floor_q, 1'b0} : 7'h00;

   always_comb begin
      state_d = state_q;
      clip_seen_d = clip_seen_q | clip_act;
      pwr_seen_d = pwr_seen_q | pwr_act;
      case (state_q)
         sgl_pkg::ST_IDLE: begin
            clip_seen_d = clip_act;
            pwr_seen_d = pwr_act;
            if (any_act) begin
               state_d = sgl_pkg::ST_ATTACK;
            end
         end
         sgl_pkg::ST_ATTACK: begin
            if (!any_act) begin
               state_d = sgl_pkg::ST_DECAY;
            end
         end
         sgl_pkg::ST_DECAY: begin
            if (any_act) begin
               state_d = sgl_pkg::ST_ATTACK;
               clip_seen_d = clip_act;
               pwr_seen_d = pwr_act;
            end else if (atten_q == 7'h00) begin
               state_d = sgl_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = sgl_pkg::ST_IDLE;
         end
      endcase
      if (!master_en_q) begin
         state_d = sgl_pkg::ST_IDLE;
      end
   end

   // Timer steps pile up and are spent only on a zero-cross, so the
   // gain moves mid-cycle only when master enable clears it; the ramp bit trades speed for smoothness
   always_comb begin
      pend_sum = pend_q;
      if ((atk_step || dcy_step) && pend_q != 5'h1f) begin
         pend_sum = pend_q + 5'h01;
      end
      apply_n = 5'h00;
      if (zero_cross) begin
         apply_n = (ramp_q && pend_sum != 5'h00) ? 5'h01 : pend_sum;
      end
      pend_d = pend_sum - apply_n;
      atten_d = atten_q;
      up_sum = {1'b0, atten_q} + {3'h0, apply_n};
      if (state_q == sgl_pkg::ST_ATTACK && zero_cross) begin
         atten_d = (up_sum > {1'b0, limit_hd}) ? limit_hd
                                               : up_sum[6:0];
      end else if (state_q == sgl_pkg::ST_DECAY && zero_cross) begin
         atten_d = ({2'h0, apply_n} > atten_q) ? 7'h00
                                               : atten_q - {2'h0, apply_n};
      end
      if (state_d != state_q) begin
         pend_d = 5'h00;
      end
      if (!master_en_q) begin
         atten_d = 7'h00;
         pend_d = 5'h00;
      end
      limiting_d = (atten_d != 7'h00);
      gain_d = {speaker_volume_stage, 1'b0} - atten_d;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= sgl_pkg::ST_IDLE;
         clip_seen_q <= 1'b0;
         pwr_seen_q <= 1'b0;
         pend_q <= 5'h00;
         atten_q <= 7'h00;
         speaker_gain_q <= 7'h00;
         limiting_q <= 1'b0;
      end else begin
         state_q <= state_d;
         clip_seen_q <= clip_seen_d;
         pwr_seen_q <= pwr_seen_d;
         pend_q <= pend_d;
         atten_q <= atten_d;
         speaker_gain_q <= gain_d;
         limiting_q <= limiting_d;
      end
   end

endmodule

// ### design/sgl_pkg.sv
// Constants shared by the speaker gain limiter control logic.
// Assumes a single 250 MHz clock and 16-bit control registers.
package sgl_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned TICK_US = 1;
   localparam int unsigned TICK_CYCLES = CLK_MHZ * TICK_US;
   localparam int unsigned STEPS_PER_6DB = 12;   // 0.5 dB per step
   localparam int unsigned STEP_CNT_W = 20;

   // Rates in microseconds per 6 dB, by code
   localparam int unsigned CLIP_ATK_US [8] =
      '{600, 5400, 10200, 15000, 19800, 24600, 34100, 34100};
   localparam int unsigned CLIP_DCY_US [8] =
      '{120000, 480000, 820000, 1170000, 1640000, 2050000, 2730000,
        4100000};
   localparam int unsigned PWR_ATK_US [8] =
      '{120000, 480000, 840000, 1200000, 1680000, 2040000, 2760000,
        4080000};
   localparam int unsigned PWR_DCY_US [8] =
      '{1080000, 1200000, 1320000, 1680000, 2040000, 2760000, 4080000,
        8160000};

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] PWR_MGMT3_ADDR = 8'h03;
   localparam logic [7:0] CLIP_CTRL_ADDR = 8'h62;
   localparam logic [7:0] PWR_CTRL_ADDR = 8'h63;
   localparam logic [7:0] LIM_CTRL2_ADDR = 8'h64;
   localparam logic [7:0] LIM_STATUS_ADDR = 8'h65;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned MASTER_EN_BIT = 14;
   localparam int unsigned DET_EN_BIT = 15;
   localparam int unsigned MEAS_MODE_BIT = 12;
   localparam int unsigned THR_LSB = 8;
   localparam int unsigned ATK_LSB = 4;
   localparam int unsigned DCY_LSB = 0;
   localparam int unsigned RAMP_BIT = 8;
   localparam int unsigned FLOOR_LSB = 0;
   localparam int unsigned LIMITING_BIT = 15;

   localparam logic MASTER_EN_RST = 1'b0;
   localparam logic CLIP_EN_RST = 1'b1;
   localparam logic [3:0] CLIP_THR_RST = 4'h6;
   localparam logic [2:0] CLIP_ATK_RST = 3'h4;
   localparam logic [2:0] CLIP_DCY_RST = 3'h0;
   localparam logic PWR_EN_RST = 1'b1;
   localparam logic PWR_MODE_RST = 1'b0;
   localparam logic [3:0] PWR_THR_RST = 4'h0;
   localparam logic [2:0] PWR_ATK_RST = 3'h0;
   localparam logic [2:0] PWR_DCY_RST = 3'h0;
   localparam logic RAMP_RST = 1'b0;
   localparam logic [5:0] FLOOR_RST = 6'h00;

   // ----------------------------------------------------------------
   // Limiter sequencing states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_ATTACK = 3'h2,
      ST_DECAY = 3'h4
   } sgl_state_t;

endpackage

// ### design/sgl_step_timer.sv
// Step timer: emits one pulse per elapsed step interval while running.
// Assumes a one-cycle tick strobe from a shared prescaler.
`timescale 1ns/1ps
module sgl_step_timer #(
   parameter int unsigned CNT_W = 20
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic run,
   input wire logic tick,
   input wire logic [CNT_W-1:0] limit,
   output logic step_q
);

   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic step_d;

   // Count ticks; restart on each step so the rate is steady
   always_comb begin
      cnt_d = cnt_q;
      step_d = 1'b0;
      if (!run) begin
         cnt_d = '0;
      end else if (tick) begin
         if (cnt_q + 1'b1 >= limit) begin
            cnt_d = '0;
            step_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt_q <= '0;
         step_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         step_q <= step_d;
      end
   end

endmodule

// ### test/sgl_limiter_asserts.sv
// Checker: gain limiter port timing and fields.
// Assumes fields change only by reg_we writes.
`timescale 1ns/1ps
module sgl_limiter_chk (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic reg_we,
   input wire logic reg_re,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata_q,
   input wire logic clip_trip,
   input wire logic power_trip_rms,
   input wire logic power_trip_inst,
   input wire logic zero_cross,
   input wire logic [5:0] speaker_volume_stage,
   input wire logic [3:0] clip_headroom_threshold_q,
   input wire logic [3:0] power_limit_threshold_q,
   input wire logic power_measure_mode_q,
   input wire logic [6:0] atten_q,
   input wire logic [6:0] speaker_gain_q,
   input wire logic limiting_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // ----------------------------------------------------------------
   // Shadow registers
   // ----------------------------------------------------------------
   logic [15:0] m3_q, m3_d, cc_q, cc_d, pc_q, pc_d, lc_q, lc_d;
   logic [15:0] rd_exp;
   logic [6:0] cap;

   // Reserved bits masked so reads can be predicted
   always_comb begin
      m3_d = m3_q;
      cc_d = cc_q;
      pc_d = pc_q;
      lc_d = lc_q;
      if (reg_we) begin
         case (reg_addr)
            sgl_pkg::PWR_MGMT3_ADDR: m3_d = reg_wdata & 16'h4000;
            sgl_pkg::CLIP_CTRL_ADDR: cc_d = reg_wdata & 16'h8f77;
            sgl_pkg::PWR_CTRL_ADDR: pc_d = reg_wdata & 16'h9f77;
            sgl_pkg::LIM_CTRL2_ADDR: lc_d = reg_wdata & 16'h013f;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         m3_q <= 16'h0000;
         cc_q <= 16'h8640;
         pc_q <= 16'h8000;
         lc_q <= 16'h0000;
      end else begin
         m3_q <= m3_d;
         cc_q <= cc_d;
         pc_q <= pc_d;
         lc_q <= lc_d;
      end
   end

   // Expected read word and cap
   always_comb begin
      case (reg_addr)
         sgl_pkg::PWR_MGMT3_ADDR: rd_exp = m3_q;
         sgl_pkg::CLIP_CTRL_ADDR: rd_exp = cc_q;
         sgl_pkg::PWR_CTRL_ADDR: rd_exp = pc_q;
         sgl_pkg::LIM_CTRL2_ADDR: rd_exp = lc_q;
         default: rd_exp = 16'h0000;
      endcase
   end
   assign cap = (speaker_volume_stage > lc_q[5:0]) ?
      {speaker_volume_stage - lc_q[5:0], 1'b0} : 7'h00;

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_rd_map;
      reg_re && reg_addr != sgl_pkg::LIM_STATUS_ADDR
         |=> reg_rdata_q == $past(rd_exp);
   endproperty
   a_rd_map: assert property (p_rd_map)
      else $error("read data mismatch");

   property p_clip_thr;
      reg_we && reg_addr == sgl_pkg::CLIP_CTRL_ADDR
         |=> clip_headroom_threshold_q == $past(reg_wdata[11:8]);
   endproperty
   a_clip_thr: assert property (p_clip_thr)
      else $error("headroom field stale");

   property p_pwr_thr;
      reg_we && reg_addr == sgl_pkg::PWR_CTRL_ADDR
         |=> power_limit_threshold_q == $past(reg_wdata[11:8])
         && power_measure_mode_q == $past(reg_wdata[12]);
   endproperty
   a_pwr_thr: assert property (p_pwr_thr)
      else $error("power field stale");

   property p_zc;
      atten_q > $past(atten_q) |-> $past(zero_cross);
   endproperty
   a_zc: assert property (p_zc)
      else $error("rise off zero-cross");

   property p_one;
      $past(lc_q[8]) && atten_q > $past(atten_q)
         |-> atten_q == $past(atten_q) + 7'h01;
   endproperty
   a_one: assert property (p_one)
      else $error("multi-step with ramp");

   property p_gain;
      $past(rst_b) |-> speaker_gain_q ==
         {$past(speaker_volume_stage), 1'b0} - atten_q;
   endproperty
   a_gain: assert property (p_gain)
      else $error("gain mismatch");

   property p_floor;
      atten_q > $past(atten_q) |-> atten_q <= $past(cap);
   endproperty
   a_floor: assert property (p_floor)
      else $error("below floor gain");

   property p_off;
      !m3_q[14] |-> ##1 atten_q == 7'h00;
   endproperty
   a_off: assert property (p_off)
      else $error("atten while disabled");

   property p_dets;
      !cc_q[15] && !pc_q[15] && atten_q == 7'h00 |=> atten_q == 7'h00;
   endproperty
   a_dets: assert property (p_dets)
      else $error("atten, detectors off");

   c_lim: cover property ($rose(limiting_q));
   c_jump: cover property (atten_q > $past(atten_q) + 7'h01);
   c_clear: cover property ($fell(limiting_q) && !m3_q[14]);
endmodule

bind sgl_limiter sgl_limiter_chk u_chk (
   .clk(clk),
   .rst_b(rst_b),
   .reg_we(reg_we),
   .reg_re(reg_re),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_rdata_q(reg_rdata_q),
   .clip_trip(clip_trip),
   .power_trip_rms(power_trip_rms),
   .power_trip_inst(power_trip_inst),
   .zero_cross(zero_cross),
   .speaker_volume_stage(speaker_volume_stage),
   .clip_headroom_threshold_q(clip_headroom_threshold_q),
   .power_limit_threshold_q(power_limit_threshold_q),
   .power_measure_mode_q(power_measure_mode_q),
   .atten_q(atten_q),
   .speaker_gain_q(speaker_gain_q),
   .limiting_q(limiting_q)
);

// ### test/sgl_host.sv
// Host model: register strobes, one access at a time.
// Assumes read data one cycle after the strobe.
`timescale 1ns/1ps
module sgl_host (
   input wire logic clk,
   output logic reg_we,
   output logic reg_re,
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata_q
);
   // Idle bus at time zero
   initial begin
      {reg_we, reg_re, reg_addr, reg_wdata} = '0;
   end

   // Data is scrambled after the strobe so stale values never help
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_re <= 1'b0;
      @(posedge clk);
      d = reg_rdata_q;
   endtask
endmodule

// ### test/test_speaker_gain_limiter.sv
// Bench for the gain limiter: registers, rates, zero-cross and cap.
// Assumes TICK_CYCLES of 2: one microsecond is two clocks.
`timescale 1ns/1ps
module test_speaker_gain_limiter;
   localparam int TK = 2;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic reg_we, reg_re;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata_q;
   logic clip_trip = 1'b0, power_trip_rms = 1'b0;
   logic power_trip_inst = 1'b0, zero_cross = 1'b0;
   logic [5:0] speaker_volume_stage = 6'h39;
   logic [3:0] clip_headroom_threshold_q, power_limit_threshold_q;
   logic power_measure_mode_q, limiting_q;
   logic [6:0] atten_q, speaker_gain_q;
   int num_errors = 0, n_tests = 0, zc_per = 20, zc_cnt = 0;
   logic [7:0] adr [6] = '{8'h03, 8'h62, 8'h63, 8'h64, 8'h65, 8'h7f};

   always #2 clk = ~clk;

   sgl_host u_sgl_host (
      .clk(clk),
      .reg_we(reg_we),
      .reg_re(reg_re),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata_q(reg_rdata_q)
   );

   sgl_limiter #(.TICK_CYCLES(TK)) u_sgl_limiter (
      .clk(clk),
      .rst_b(rst_b),
      .reg_we(reg_we),
      .reg_re(reg_re),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata_q(reg_rdata_q),
      .clip_trip(clip_trip),
      .power_trip_rms(power_trip_rms),
      .power_trip_inst(power_trip_inst),
      .zero_cross(zero_cross),
      .speaker_volume_stage(speaker_volume_stage),
      .clip_headroom_threshold_q(clip_headroom_threshold_q),
      .power_limit_threshold_q(power_limit_threshold_q),
      .power_measure_mode_q(power_measure_mode_q),
      .atten_q(atten_q),
      .speaker_gain_q(speaker_gain_q),
      .limiting_q(limiting_q)
   );

   // Periodic zero-cross; a zero period holds it low
   always @(posedge clk) begin
      zc_cnt <= (zc_cnt >= zc_per - 1) ? 0 : zc_cnt + 1;
      zero_cross <= zc_per != 0 && zc_cnt == 0;
   end

   // ----------------------------------------------------------------
   // Expectations and checks
   // ----------------------------------------------------------------
   function automatic logic [15:0] rst_val(input logic [7:0] a);
      case (a)
         sgl_pkg::CLIP_CTRL_ADDR: return 16'h8640;
         sgl_pkg::PWR_CTRL_ADDR: return 16'h8000;
         default: return 16'h0000;
      endcase
   endfunction

   // Writable bits by address
   function automatic logic [15:0] msk(input logic [7:0] a);
      case (a)
         sgl_pkg::PWR_MGMT3_ADDR: return 16'h4000;
         sgl_pkg::CLIP_CTRL_ADDR: return 16'h8f77;
         sgl_pkg::PWR_CTRL_ADDR: return 16'h9f77;
         sgl_pkg::LIM_CTRL2_ADDR: return 16'h013f;
         default: return 16'h0000;
      endcase
   endfunction

   function automatic int stp(input int unsigned us);
      return us / 12 * TK;
   endfunction

   function automatic logic [6:0] cap_f(input logic [5:0] v, f);
      return (v > f) ? {v - f, 1'b0} : 7'h00;
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Times the next attenuation change; slack covers tick and zero-cross
   task automatic step_chk(input int s);
      int n;
      logic [6:0] a0;
      @(negedge clk);
      a0 = atten_q;
      n = 0;
      while (atten_q === a0 && n < 30000) begin
         @(negedge clk);
         n++;
      end
      chk(16'(n >= s - 2 * TK && n <= s + 40), 16'h0001);
   endtask

   task automatic mst(input logic on);
      u_sgl_host.wr(sgl_pkg::PWR_MGMT3_ADDR, on ? 16'h4000 : 16'h0000);
   endtask

   task automatic stop_test();
      if (num_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge clk);
      num_errors++;
      stop_test();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [15:0] d, w;
      logic [7:0] a;
      logic [5:0] v, f;
      void'($urandom(43523));
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      foreach (adr[i]) begin
         u_sgl_host.rd(adr[i], d);
         chk(d, rst_val(adr[i]));
      end
      repeat (24) begin
         a = adr[$urandom % 6];
         w = 16'($urandom);
         u_sgl_host.wr(a, w);
         u_sgl_host.rd(a, d);
         chk(d, w & msk(a));
      end
      // Master off, then both detectors off: a held trip must leave the gain alone
      u_sgl_host.wr(sgl_pkg::LIM_CTRL2_ADDR, 16'h0100);
      u_sgl_host.wr(sgl_pkg::CLIP_CTRL_ADDR, 16'h0000);
      u_sgl_host.wr(sgl_pkg::PWR_CTRL_ADDR, 16'h1000);
      mst(0);
      clip_trip <= 1'b1;
      power_trip_rms <= 1'b1;
      repeat (600) @(negedge clk);
      chk(16'(atten_q), 16'h0000);
      mst(1);
      repeat (600) @(negedge clk);
      chk(16'(atten_q), 16'h0000);
      mst(0);
      power_trip_rms <= 1'b0;
      u_sgl_host.wr(sgl_pkg::PWR_CTRL_ADDR, 16'h9000);
      // Every anti-clip attack code, clip trip alone
      for (int k = 0; k < 8; k++) begin
         mst(0);
         u_sgl_host.wr(sgl_pkg::CLIP_CTRL_ADDR, 16'h8000 | 16'(k << 4));
         mst(1);
         step_chk(stp(sgl_pkg::CLIP_ATK_US[k]));
      end
      @(posedge clk);
      clip_trip <= 1'b0;
      step_chk(stp(sgl_pkg::CLIP_DCY_US[0]));
      // One late zero-cross releases several steps
      mst(0);
      u_sgl_host.wr(sgl_pkg::CLIP_CTRL_ADDR, 16'h8000);
      u_sgl_host.wr(sgl_pkg::LIM_CTRL2_ADDR, 16'h0000);
      zc_per <= 0;
      clip_trip <= 1'b1;
      mst(1);
      repeat (1000) @(posedge clk);
      zc_per <= 1;
      @(posedge clk);
      zc_per <= 0;
      repeat (2) @(negedge clk);
      chk(16'(atten_q >= 7'd8 && atten_q <= 7'd11), 16'h0001);
      // Floor cap; first case has floor above volume
      for (int j = 0; j < 4; j++) begin
         v = (j == 0) ? 6'h03 : 6'($urandom_range(63, 8));
         f = (j == 0) ? 6'h05 : v - 6'($urandom % 7);
         mst(0);
         zc_per <= 20;
         speaker_volume_stage <= v;
         u_sgl_host.wr(sgl_pkg::LIM_CTRL2_ADDR, {10'h000, f});
         mst(1);
         repeat (1600) @(negedge clk);
         chk(16'(atten_q), 16'(cap_f(v, f)));
         chk(16'(speaker_gain_q), 16'({v, 1'b0} - cap_f(v, f)));
      end
      // Both trips: clip rate; instantaneous power alone: own rate
      mst(0);
      speaker_volume_stage <= 6'h39;
      u_sgl_host.wr(sgl_pkg::LIM_CTRL2_ADDR, 16'h0100);
      power_trip_rms <= 1'b1;
      mst(1);
      step_chk(stp(sgl_pkg::CLIP_ATK_US[0]));
      mst(0);
      clip_trip <= 1'b0;
      power_trip_rms <= 1'b0;
      power_trip_inst <= 1'b1;
      u_sgl_host.wr(sgl_pkg::PWR_CTRL_ADDR, 16'h8000);
      mst(1);
      step_chk(stp(sgl_pkg::PWR_ATK_US[0]));
      stop_test();
   end
endmodule
